// File: rtl/clm_pkg.sv
/*
 * Shared constants and types for the main clock loss monitor.
 * Assumes a 32-bit classic Wishbone register bus and one core clock.
 */
package clm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] MODE_ADDR = 32'hffff_f870;
  localparam logic [31:0] KEY_ADDR = 32'hffff_f874;
  localparam logic [31:0] RSRC_ADDR = 32'hffff_f878;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hffff_f87c;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffff_f880;
  localparam logic [31:0] STATUS_ADDR = 32'hffff_f884;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int unsigned ENABLE_BIT = 0;
  localparam logic [7:0] KEY_VALUE = 8'ha5;
  localparam int unsigned LOSS_FLAG_BIT = 0;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_LOSS_BIT = 0;
  localparam int unsigned IRQ_PROT_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_SUSP_BIT = 1;
  localparam int unsigned STAT_ARMED_BIT = 2;

  // ****************************************************************
  // Timing counts, in internal oscillator ticks, and the counter width
  // ****************************************************************
  localparam int unsigned RESET_TICKS = 4;
  localparam int unsigned LOSS_TICKS = 8;
  localparam int unsigned CNT_W = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic stop_mode;
    logic osc_stab_count;
    logic main_clock_stop_bit;
    logic clock_select_status;
    logic int_osc_stopped;
    logic cpu_on_internal_osc_flag;
  } clm_susp_s;

  typedef enum logic {
    ST_WATCH,
    ST_RESET
  } clm_state_e;

endpackage

// File: rtl/clm_loss_det.sv
/*
 * Main clock activity detector, counted in internal oscillator ticks.
 * Assumes activity_i toggles with the main clock and osc_tick_i is a
 * one-cycle pulse per internal oscillator period.
 */
module clm_loss_det
  import clm_pkg::*;
#(
  parameter int unsigned CW = CNT_W,
  parameter logic [CNT_W-1:0] LIMIT = CNT_W'(LOSS_TICKS)
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic activity_i,
  input wire logic osc_tick_i,
  input wire logic clear_i,
  output logic loss_o
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic seen;
  logic [CW-1:0] idle_cnt;

  // Activity seen since the last tick
  wire edge_w = sync2 ^ sync3;
  wire seen_w = seen | edge_w;

  // ****************************************************************
  // Synchroniser and idle counter
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (clk_en_i) begin
      sync1 <= activity_i; // [R14]
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      seen <= 1'b0;
      idle_cnt <= '0;
      loss_o <= 1'b0;
    end else if (clk_en_i) begin
      if (clear_i) begin
        // Stale history must not survive a pause
        seen <= 1'b0; // [R15]
        idle_cnt <= '0; // [R15]
        loss_o <= 1'b0;
      end else if (osc_tick_i) begin
        seen <= 1'b0;
        if (seen_w) begin
          idle_cnt <= '0;
        end else if (idle_cnt != LIMIT) begin
          idle_cnt <= idle_cnt + 1'b1;
        end
        loss_o <= !seen_w && (idle_cnt + 1'b1 >= LIMIT); // [R14]
      end else begin
        seen <= seen_w;
      end
    end
  end

endmodule

// File: rtl/clm_top.sv
/*
 * Main clock loss monitor: Wishbone register slave, suspend logic,
 * loss detection and the internal reset pulse.
 * Assumes all inputs synchronous to core_clk_i, osc_tick_i marking
 * internal oscillator periods, and the chip reset controller
 * consuming int_rst_n_o.
 */
// Design decision made here: register access over Wishbone.

// Function
// R1 - Mode register writes need protected key sequence
// R2 - Mode register allows byte and bit access
// R3 - Mode resets zero; only bit 0 used
// R4 - Enable sets by one; only reset clears
// R5 - Clock loss reset clears enable, sets flag
// R6 - Loss drives low reset four oscillator periods
// R7 - External reset clears enable, halts monitoring
// R8 - Pause in STOP and stabilisation count
// R9 - Pause from stop bit until main select
// R10 - Resume automatically when main clock restarts
// R11 - Pause while sampling oscillator is stopped
// R12 - Pause while CPU runs on oscillator
// R13 - Sub-idle monitors unless stop bit set
// R14 - Judge loss by synchronised activity count
// R15 - Any pause clears the loss counter
module clm_top
  import clm_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOSS_LIMIT = CNT_W'(LOSS_TICKS),
  parameter logic [2:0] RESET_LEN = 3'(RESET_TICKS)
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic main_activity_i,
  input wire logic osc_tick_i,
  input wire clm_susp_s susp_i,
  output logic int_rst_n_o,
  output logic monitor_active_o,
  output logic irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic monitor_enable;
  logic clock_loss_reset_flag;
  logic armed;
  // Latched stop request: main clock off while running from subclock
  logic main_stop_hold;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [2:0] pulse_cnt;
  clm_state_e state;
  clm_state_e next_state;
  logic loss;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte-lane-0 write to one register; every writable register uses it
  function automatic logic lane0_write(
    input logic wr,
    input logic sel0,
    input logic hit
  );
    return wr && sel0 && hit;
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Registered ack: every access takes exactly one wait state
  wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_w = req_w && wb_we_i;
  wire lane0_w = wb_sel_i[0];
  wire hit_mode_w = wb_adr_i == MODE_ADDR;
  wire hit_key_w = wb_adr_i == KEY_ADDR;
  wire hit_rsrc_w = wb_adr_i == RSRC_ADDR;
  wire hit_stat_w = wb_adr_i == IRQ_STAT_ADDR;
  wire hit_mask_w = wb_adr_i == IRQ_MASK_ADDR;
  wire hit_sts_w = wb_adr_i == STATUS_ADDR;

  // Key write arms the very next bus write only; reads leave it armed
  wire key_ok_w = lane0_write(wr_w, lane0_w, hit_key_w) && wb_dat_i[7:0] == KEY_VALUE;
  wire mode_wr_w = lane0_write(wr_w, lane0_w, hit_mode_w);
  wire rsrc_wr_w = lane0_write(wr_w, lane0_w, hit_rsrc_w);
  wire stat_wr_w = lane0_write(wr_w, lane0_w, hit_stat_w);
  wire mask_wr_w = lane0_write(wr_w, lane0_w, hit_mask_w);
  wire mode_ok_w = mode_wr_w && armed; // [R1]
  wire prot_err_w = mode_wr_w && !armed; // [R1]

  // Only a one is honoured; a written zero leaves the bit alone
  wire set_en_w = mode_ok_w && wb_dat_i[ENABLE_BIT]; // [R4]

  // ****************************************************************
  // Suspend conditions
  // ****************************************************************
  // Hold from the stop bit during subclock use until main is selected
  wire next_main_stop_hold = susp_i.clock_select_status
    && (main_stop_hold || susp_i.main_clock_stop_bit); // [R9] [R10] [R13]

  // The hold's next value is used so the pause starts in the cycle of
  // the stop bit, before the stopped clock can look lost
  wire suspend_w = susp_i.stop_mode // [R8]
    || susp_i.osc_stab_count // [R8]
    || next_main_stop_hold // [R9]
    || susp_i.int_osc_stopped // [R11]
    || susp_i.cpu_on_internal_osc_flag; // [R12]

  wire watching_w = monitor_enable && !suspend_w && state == ST_WATCH;
  wire fire_w = watching_w && loss;

  // ****************************************************************
  // Loss detector
  // ****************************************************************
  // Held clear whenever checking is off, so resuming never fires on
  // activity history gathered before a pause
  clm_loss_det #(
    .CW(CNT_W),
    .LIMIT(LOSS_LIMIT)
  ) u_det (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_en_i(clk_en_i),
    .activity_i(main_activity_i),
    .osc_tick_i(osc_tick_i),
    .clear_i(!watching_w), // [R15]
    .loss_o(loss)
  );

  // ****************************************************************
  // Reset pulse sequencer
  // ****************************************************************
  // Ticks are counted only inside the pulse; the firing cycle loads the
  // count, so the low time always holds exactly RESET_LEN oscillator ticks
  wire pulse_done_w = osc_tick_i && pulse_cnt == 3'd1;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_WATCH: begin
        if (fire_w) begin
          next_state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (pulse_done_w) begin
          next_state = ST_WATCH;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= ST_WATCH;
      pulse_cnt <= '0;
      int_rst_n_o <= 1'b1;
    end else if (clk_en_i) begin
      state <= next_state;
      if (fire_w) begin
        pulse_cnt <= RESET_LEN; // [R6]
      end else if (state == ST_RESET && osc_tick_i) begin
        pulse_cnt <= pulse_cnt - 3'd1; // [R6]
      end
      // Taken from the next state so the pulse starts with the fire
      int_rst_n_o <= next_state != ST_RESET; // [R6]
    end
  end

  // ****************************************************************
  // Mode register and write protection
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      main_stop_hold <= 1'b0;
    end else if (clk_en_i) begin
      main_stop_hold <= next_main_stop_hold; // [R9] [R10]
    end
  end

  // Any write, mapped or not, spends the key
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      armed <= 1'b0;
    end else if (clk_en_i && wr_w) begin
      armed <= key_ok_w; // [R1]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      monitor_enable <= MODE_RESET[ENABLE_BIT]; // [R3] [R7]
    end else if (clk_en_i) begin
      // The monitor's own reset outranks a simultaneous set
      if (fire_w) begin
        monitor_enable <= 1'b0; // [R5]
      end else if (set_en_w) begin
        monitor_enable <= 1'b1; // [R4]
      end
    end
  end

  // ****************************************************************
  // Reset cause
  // ****************************************************************
  // Cause flag survives the pulse it reports; set beats clear
  wire rsrc_clr_w = rsrc_wr_w && wb_dat_i[LOSS_FLAG_BIT];

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      clock_loss_reset_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (fire_w) begin
        clock_loss_reset_flag <= 1'b1; // [R5]
      end else if (rsrc_clr_w) begin
        clock_loss_reset_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_mask;

  assign irq_evt[IRQ_LOSS_BIT] = fire_w;
  assign irq_evt[IRQ_PROT_BIT] = prot_err_w;
  assign irq_clr = stat_wr_w ? wb_dat_i[IRQ_W-1:0] : '0;
  assign next_irq_mask = mask_wr_w ? wb_dat_i[IRQ_W-1:0] : irq_mask;

  // Per-bit sticky status; an event in the clearing cycle wins
  for (genvar gi = 0; gi < IRQ_W; gi++) begin : g_irq
    assign next_irq_stat[gi] = irq_evt[gi] | (irq_stat[gi] & ~irq_clr[gi]);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end else if (clk_en_i) begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // Next mask is used so a mask write acts in the cycle of the write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ****************************************************************
  // Read data and acknowledge
  // ****************************************************************
  logic [7:0] mode_rd;
  logic [7:0] sts_rd;
  logic [31:0] rd_mux;

  // Upper mode bits are hard zero
  assign mode_rd = {7'h00, monitor_enable}; // [R3]
  assign sts_rd = {5'h00, armed, suspend_w, watching_w};
  // Unmapped addresses read as zero
  assign rd_mux = hit_mode_w ? {24'h00_0000, mode_rd} : // [R2]
    hit_rsrc_w ? {31'h0000_0000, clock_loss_reset_flag} :
    hit_stat_w ? {30'h0000_0000, irq_stat} :
    hit_mask_w ? {30'h0000_0000, irq_mask} :
    hit_sts_w ? {24'h00_0000, sts_rd} :
    32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      wb_ack_o <= req_w;
      wb_dat_o <= (req_w && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Drops with the reset pulse, not one cycle behind it
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      monitor_active_o <= 1'b0;
    end else if (clk_en_i) begin
      monitor_active_o <= watching_w && !fire_w; // [R6]
    end
  end

endmodule

// File: verif/clm_osc_model.sv
/*
 * Partner model: main clock activity level and internal oscillator ticks.
 * Assumes the bench gates each source to mimic a stopped oscillator.
 */
module clm_osc_model #(
  parameter int DIV = 4
) (
  input wire logic core_clk_i,
  input wire logic main_run_i,
  input wire logic osc_run_i,
  output logic activity_o,
  output logic tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_cnt = 8'h00;
  initial begin
    activity_o = 1'b0;
    tick_o = 1'b0;
  end
  // ****************************************
  // Sources
  // ****************************************
  // A stopped oscillator freezes its last level, so no toggle is seen
  always @(posedge core_clk_i) begin
    if (main_run_i) begin
      activity_o <= ~activity_o;
    end
    div_cnt <= (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
    tick_o <= osc_run_i && (div_cnt == 8'(DIV - 1));
  end
endmodule

// File: verif/clm_top_properties.sv
/*
 * Port checker for the clock loss monitor, bound to clm_top.
 * Assumes clk_en_i high whenever requests or ticks must be judged.
 */
module clm_top_properties
  import clm_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOSS_LIMIT = CNT_W'(LOSS_TICKS),
  parameter logic [2:0] RESET_LEN = 3'(RESET_TICKS)
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic osc_tick_i,
  input wire clm_susp_s susp_i,
  input wire logic int_rst_n_o,
  input wire logic monitor_active_o,
  input wire logic irq_o
);
  // ****************************************
  // Helper: oscillator ticks seen during the reset pulse
  // ****************************************
  logic [3:0] low_ticks;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || int_rst_n_o) begin
      low_ticks <= 4'h0;
    end else if (osc_tick_i) begin
      low_ticks <= low_ticks + 4'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_rst_len;
    $rose(int_rst_n_o) |-> low_ticks == 4'(RESET_LEN);
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("pulse too short");
  property p_rst_max;
    !int_rst_n_o |-> low_ticks <= 4'(RESET_LEN);
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("pulse too long");
  property p_quiet_in_pulse;
    !int_rst_n_o |-> !monitor_active_o;
  endproperty
  a_quiet_in_pulse: assert property (p_quiet_in_pulse) else $error("active in pulse");
  property p_loss_from_watch;
    $fell(int_rst_n_o) |-> $past(monitor_active_o);
  endproperty
  a_loss_from_watch: assert property (p_loss_from_watch) else $error("stale loss");
  property p_susp_halt;
    susp_i.stop_mode || susp_i.osc_stab_count || susp_i.int_osc_stopped
      || susp_i.cpu_on_internal_osc_flag |=> !monitor_active_o;
  endproperty
  a_susp_halt: assert property (p_susp_halt) else $error("checks in pause");
  property p_main_stop;
    susp_i.clock_select_status && susp_i.main_clock_stop_bit |=> !monitor_active_o;
  endproperty
  a_main_stop: assert property (p_main_stop) else $error("checks while stopped");
  property p_sticky;
    $fell(monitor_active_o) |-> $past(susp_i) != 6'h00 || !int_rst_n_o || $past(srst_i);
  endproperty
  a_sticky: assert property (p_sticky) else $error("enable lost");
  property p_srst;
    $past(srst_i) |-> int_rst_n_o && !monitor_active_o && !irq_o;
  endproperty
  a_srst: assert property (p_srst) else $error("bad reset state");
  c_loss: cover property ($fell(int_rst_n_o));
  c_active: cover property ($rose(monitor_active_o));
  c_irq: cover property ($rose(irq_o));
endmodule

bind clm_top clm_top_properties #(.LOSS_LIMIT(LOSS_LIMIT), .RESET_LEN(RESET_LEN)) props_u (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_tick_i(osc_tick_i),
  .susp_i(susp_i), .int_rst_n_o(int_rst_n_o), .monitor_active_o(monitor_active_o),
  .irq_o(irq_o));

// File: verif/main_clock_loss_monitor_bench.sv
/*
 * Self-checking bench: Wishbone accesses, pauses, loss reset, irq.
 * Assumes the oscillator model and the bound port checker.
 */
module main_clock_loss_monitor_bench;
  import clm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b1;
  logic ack, tick, act, rst_n, mon, irq;
  logic [31:0] adr = '0, dat = '0, rdat, q;
  logic [3:0] sel = 4'h1;
  logic [5:0] sv [5] = '{6'h20, 6'h10, 6'h02, 6'h01, 6'h0c};
  clm_susp_s susp = '0;
  int n_errors = 0, num_checks = 0, k;
  always #4 clk = ~clk;
  clm_osc_model osc_u (.core_clk_i(clk), .main_run_i(run), .osc_run_i(!susp.int_osc_stopped),
    .activity_o(act), .tick_o(tick));
  // Short loss limit keeps the run brief
  clm_top #(.LOSS_LIMIT(8'h02)) dut_u (.core_clk_i(clk), .srst_i(srst), .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .main_activity_i(act),
    .osc_tick_i(tick), .susp_i(susp), .int_rst_n_o(rst_n), .monitor_active_o(mon),
    .irq_o(irq));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    {cyc, stb} <= 2'b00;
    chk1(ack, 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Whole run needs well under a thousand cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(MODE_ADDR, 32'h0000_0000);
    rd(32'hffff_f8f0, 32'h0000_0000);
    wr(MODE_ADDR, 32'h0000_0001);
    wr(IRQ_MASK_ADDR, 32'h0000_0003);
    rd(IRQ_STAT_ADDR, 32'h0000_0002);
    chk1(irq, 1'b1);
    wr(IRQ_STAT_ADDR, 32'h0000_0002);
    rd(MODE_ADDR, 32'h0000_0000);
    chk1(irq, 1'b0);
    wr(KEY_ADDR, 32'h0000_00a5);
    wr(IRQ_MASK_ADDR, 32'h0000_0003);
    wr(MODE_ADDR, 32'h0000_0001);
    rd(MODE_ADDR, 32'h0000_0000);
    wr(IRQ_STAT_ADDR, 32'h0000_0002);
    wr(KEY_ADDR, 32'h0000_00a5);
    wr(MODE_ADDR, 32'h0000_00ff);
    rd(MODE_ADDR, 32'h0000_0001);
    wr(KEY_ADDR, 32'h0000_00a5);
    wr(MODE_ADDR, 32'h0000_0000);
    rd(MODE_ADDR, 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk1(mon, 1'b1);
    chk1(rst_n, 1'b1);
    rd(STATUS_ADDR, 32'h0000_0001);
    foreach (sv[i]) begin
      susp <= sv[i];
      run <= 1'b0;
      repeat (40) @(posedge clk);
      chk1(mon, 1'b0);
      chk1(rst_n, 1'b1);
      run <= 1'b1;
      susp <= sv[i] & 6'h04;
      repeat (20) @(posedge clk);
      chk1(mon, sv[i] != 6'h0c);
      susp <= '0;
      repeat (20) @(posedge clk);
      chk1(mon, 1'b1);
    end
    susp <= 6'h04;
    repeat (40) @(posedge clk);
    chk1(mon, 1'b1);
    susp <= '0;
    run <= 1'b0;
    for (int i = 0; i < 200 && rst_n !== 1'b0; i++) @(posedge clk);
    k = 0;
    for (int i = 0; i < 200 && rst_n === 1'b0; i++) begin
      if (tick === 1'b1) k++;
      @(posedge clk);
    end
    chk(k, 32'h0000_0004);
    run <= 1'b1;
    rd(MODE_ADDR, 32'h0000_0000);
    rd(RSRC_ADDR, 32'h0000_0001);
    rd(IRQ_STAT_ADDR, 32'h0000_0001);
    chk1(irq, 1'b1);
    wr(RSRC_ADDR, 32'h0000_0001);
    rd(RSRC_ADDR, 32'h0000_0000);
    wr(KEY_ADDR, 32'h0000_00a5);
    sel <= 4'h0;
    wr(MODE_ADDR, 32'h0000_0001);
    sel <= 4'h1;
    rd(MODE_ADDR, 32'h0000_0000);
    rd(IRQ_STAT_ADDR, 32'h0000_0001);
    wr(KEY_ADDR, 32'h0000_00a5);
    wr(MODE_ADDR, 32'h0000_0001);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rd(MODE_ADDR, 32'h0000_0000);
    run <= 1'b0;
    repeat (60) @(posedge clk);
    chk1(rst_n, 1'b1);
    stop_test;
  end
endmodule
